// ==== common/odp_regs_map.svh ====
// Register map constants for the output driver protection register slice.
// Assumes inclusion by bare name from the package and modules.
`ifndef ODP_REGS_MAP_SVH
`define ODP_REGS_MAP_SVH

`define ODP_OFF_PAGE_SELECT 7'h00
`define ODP_OFF_ERROR_POLICY 7'h1E
`define ODP_OFF_HP_DRIVER 7'h1F
`define ODP_OFF_PIN_GAIN 7'h75
`define ODP_OFF_RSVD_LO 7'h76
`define ODP_OFF_RSVD_HI 7'h7F

`define ODP_PAGE_GAIN 8'h00
`define ODP_PAGE_DRIVER 8'h01

`define ODP_RST_PAGE_SELECT 8'h00
`define ODP_RST_ERROR_POLICY 8'h00
`define ODP_RST_HP_DRIVER 8'h04
`define ODP_RST_PIN_GAIN 7'h00

`define ODP_BIT_HP_LEFT_PWR 7
`define ODP_BIT_HP_RIGHT_PWR 6
`define ODP_BIT_HP_RSVD_ZERO 5
`define ODP_BIT_HP_CM_HI 4
`define ODP_BIT_HP_CM_LO 3
`define ODP_BIT_HP_RSVD_ONE 2
`define ODP_BIT_HP_PROT_MODE 1
`define ODP_BIT_HP_SHORT 0
`define ODP_BIT_POL_HP 1
`define ODP_BIT_POL_SP 0

`define ODP_GAIN_RESERVED 7'h7F

`endif

// ==== common/odp_regs_pkg.sv ====
// Types shared by the output driver protection register slice.
// Assumes the map header sits on the include path.
`include "odp_regs_map.svh"

package odp_regs_pkg;

    // Register access from the serial control port decoder
    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } odp_reg_req_t;

    // Headphone driver analog controls
    typedef struct packed {
        logic left_headphone_driver_pwr;
        logic right_headphone_driver_pwr;
        logic [1:0] common_mode_sel;
        logic protect_power_down;
        logic protect_limit_current;
    } odp_hp_ctrl_t;

    typedef enum logic [1:0] {
        ODP_CM_1V35 = 2'h0,
        ODP_CM_1V50 = 2'h1,
        ODP_CM_1V65 = 2'h2,
        ODP_CM_1V80 = 2'h3
    } odp_cm_level_t;

endpackage

// ==== dv/odp_host_model.sv ====
// Host on the control port: one request per call; wr makes none for addresses 7'h76 and up.
// Assumes single-cycle strobes and rvalid one cycle on.
`timescale 1ns/10ps
module odp_host_model (
    input wire logic clock,
    output odp_regs_pkg::odp_reg_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    // ====
    // Access
    initial req = '0;
    task automatic access(input logic w, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clock);
        #2;
        req = {w, !w, a, d};
        @(posedge clock);
        #2;
        // Idle bus shows inverted values so stale data never looks valid
        req = {2'b00, ~a, ~d};
        q = rvalid ? rdata : 8'hXX;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] q;
        if (a >= 7'h76) return;
        if (a == 7'h75) d[7] = 1'b0;
        if (a == 7'h1F) d[2] = 1'b1;
        access(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] q);
        access(1'b0, a, 8'h00, q);
    endtask
endmodule

// ==== dv/odp_regs_bench.sv ====
// Self-checking bench for odp_regs.
// Assumes host model and checker compiled first.
`timescale 1ns/10ps
module odp_regs_bench;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    odp_regs_pkg::odp_reg_req_t req;
    odp_regs_pkg::odp_hp_ctrl_t hp_ctrl;
    logic [7:0] rdata, q;
    logic rvalid, hs = 1'b0, ss = 1'b0, spw = 1'b0;
    logic [1:0] spd = 2'b00, spk;
    logic [6:0] gain = 7'h23;
    int n_errors = 0, compares = 0;
    // Rows: page, addr, wdata, expected read
    logic [31:0] rows [10] = '{32'h011E0202, 32'h011E0101, 32'h011F1C1C, 32'h011FC4C4, 32'h011F0C0C,
        32'h011F1414, 32'h00750023, 32'h001FFF00, 32'h021F5500, 32'hFF00FFFF};
    // Trips: policy, hp write, expected hp read, speaker power
    logic [31:0] trips [3] = '{32'h00C60700, 32'h03C6C703, 32'h00C4C500};
    always #12.5 clock = ~clock;
    odp_regs dut_u (.clock, .sys_rst, .req, .rdata, .rvalid, .volume_sense_pin_gain(gain),
        .headphone_short_raw(hs), .speaker_short_raw(ss), .hp_ctrl, .left_speaker_driver_pwr(spk[1]),
        .right_speaker_driver_pwr(spk[0]), .speaker_pwr_wr(spw), .speaker_pwr_wdata(spd));
    odp_host_model host_u (.clock, .req, .rdata, .rvalid);
    // ====
    // Tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #20000;
        n_errors++;
        report_and_stop();
    end
    // ====
    // Sequence
    initial begin
        repeat (4) @(posedge clock);
        #2;
        sys_rst = 1'b0;
        foreach (rows[i]) begin
            host_u.wr(7'h00, rows[i][31:24]);
            host_u.wr(rows[i][22:16], rows[i][15:8]);
            host_u.rd(rows[i][22:16], q);
            chk(q, rows[i][7:0]);
            if (rows[i][31:16] == 16'h011F) begin
                chk({6'h00, hp_ctrl.common_mode_sel}, {6'h00, rows[i][12:11]});
                chk({6'h00, hp_ctrl.left_headphone_driver_pwr, hp_ctrl.right_headphone_driver_pwr},
                    {6'h00, rows[i][15:14]});
            end
        end
        host_u.wr(7'h00, 8'h01);
        foreach (trips[i]) begin
            host_u.wr(7'h1E, trips[i][31:24]);
            host_u.wr(7'h1F, trips[i][23:16]);
            spw = 1'b1;
            spd = 2'b11;
            @(posedge clock);
            #2;
            spw = 1'b0;
            hs = 1'b1;
            ss = 1'b1;
            repeat (4) @(posedge clock);
            host_u.rd(7'h1F, q);
            chk(q, trips[i][15:8]);
            chk({6'h00, spk}, trips[i][7:0]);
            chk({6'h00, hp_ctrl.protect_power_down, hp_ctrl.protect_limit_current},
                {6'h00, trips[i][17], !trips[i][17]});
            hs = 1'b0;
            ss = 1'b0;
            repeat (4) @(posedge clock);
        end
        // A new pin code must reach the readback after the synchroniser latency
        #2;
        gain = 7'h7E;
        host_u.wr(7'h00, 8'h00);
        repeat (2) @(posedge clock);
        host_u.rd(7'h75, q);
        chk(q, 8'h7E);
        sys_rst = 1'b1;
        repeat (4) @(posedge clock);
        #2;
        sys_rst = 1'b0;
        host_u.rd(7'h00, q);
        chk(q, 8'h00);
        host_u.wr(7'h00, 8'h01);
        host_u.rd(7'h1F, q);
        chk(q, 8'h04);
        report_and_stop();
    end
endmodule
bind odp_regs odp_regs_properties chk_u (.clock, .sys_rst, .req, .rdata, .rvalid, .headphone_short_raw,
    .hp_ctrl, .left_speaker_driver_pwr, .speaker_pwr_wr, .speaker_pwr_wdata);

// ==== dv/odp_regs_properties.sv ====
// Port checks for the driver register slice.
// Bound to odp_regs in the bench top file.
`timescale 1ns/10ps
module odp_regs_properties (
    input wire logic clock,
    input wire logic sys_rst,
    input wire odp_regs_pkg::odp_reg_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    input wire logic headphone_short_raw,
    input wire odp_regs_pkg::odp_hp_ctrl_t hp_ctrl,
    input wire logic left_speaker_driver_pwr,
    input wire logic speaker_pwr_wr,
    input wire logic [1:0] speaker_pwr_wdata
);
    // ====
    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    a_read_gets_answer: assert property (req.rd |=> rvalid)
        else $error("no answer");
    a_answer_has_cause: assert property (rvalid |-> $past(req.rd))
        else $error("stray answer");
    a_rdata_holds: assert property (!rvalid |-> $stable(rdata))
        else $error("rdata moved");
    a_hp_power_write: assert property ($rose(hp_ctrl.left_headphone_driver_pwr) |->
        $past(req.wr) && $past(req.wdata[7]) && $past(req.addr) == 7'h1F)
        else $error("hp power rose");
    a_cm_write: assert property ($changed(hp_ctrl.common_mode_sel) |-> $past(req.wr))
        else $error("cm moved");
    a_spk_power_write: assert property ($rose(left_speaker_driver_pwr) |->
        $past(speaker_pwr_wr) && $past(speaker_pwr_wdata[1]))
        else $error("spk power rose");
    a_trip_cause: assert property (hp_ctrl.protect_power_down |-> $past(headphone_short_raw, 2))
        else $error("trip without short");
    a_modes_apart: assert property (!(hp_ctrl.protect_power_down && hp_ctrl.protect_limit_current))
        else $error("both modes");
endmodule

// ==== rtl/odp_regs.sv ====
// Output driver control and short-circuit protection registers of an audio codec.
// Assumes a serial control port decoder presents one-cycle read/write strobes
// in the digital clock domain; analog short detectors and the volume ADC are asynchronous.
//
// Function
// - Read-only 7-bit pin volume gain code
// - Page select, 8-bit, resets to zero
// - Headphone policy zero clears headphone power bits in power-down mode only
// - Speaker policy zero clears speaker power bits
// - Headphone left/right power bits at top
// - Two-bit headphone common-mode level select
// - Protection mode: limit current or power down
// - Bit zero reads live headphone short status
`timescale 1ns/10ps
`include "odp_regs_map.svh"

module odp_regs (
    input wire logic clock,
    input wire logic sys_rst,
    input wire odp_regs_pkg::odp_reg_req_t req,
    output logic [7:0] rdata,
    output logic rvalid,
    input wire logic [6:0] volume_sense_pin_gain,
    input wire logic headphone_short_raw,
    input wire logic speaker_short_raw,
    output odp_regs_pkg::odp_hp_ctrl_t hp_ctrl,
    output logic left_speaker_driver_pwr,
    output logic right_speaker_driver_pwr,
    input wire logic speaker_pwr_wr,
    input wire logic [1:0] speaker_pwr_wdata
);

    // ========================================
    // Input synchronisation
    logic [8:0] sync_in;
    logic [8:0] sync_out;
    logic [6:0] gain_sync;
    logic hp_short;
    logic sp_short;

    assign sync_in = {volume_sense_pin_gain, headphone_short_raw, speaker_short_raw};

    // Gain bits are sampled independently; a code may be torn during one update cycle
    odp_sync2 #(.WIDTH(9)) u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .async_in(sync_in),
        .sync_out(sync_out)
    );

    assign gain_sync = sync_out[8:2];
    assign hp_short = sync_out[1];
    assign sp_short = sync_out[0];

    // ========================================
    // Decode
    logic [7:0] page_q;
    logic sel_page;
    logic sel_policy;
    logic sel_hp;
    logic sel_gain;

    assign sel_page = (req.addr == `ODP_OFF_PAGE_SELECT);
    assign sel_policy = (page_q == `ODP_PAGE_DRIVER) && (req.addr == `ODP_OFF_ERROR_POLICY);
    assign sel_hp = (page_q == `ODP_PAGE_DRIVER) && (req.addr == `ODP_OFF_HP_DRIVER);
    assign sel_gain = (page_q == `ODP_PAGE_GAIN) && (req.addr == `ODP_OFF_PIN_GAIN);

    // Reserved slots and unmapped pages, except page select at address 0 on every page, fall through: reads give zero, writes are dropped
    logic wr_page;
    logic wr_policy;
    logic wr_hp;

    assign wr_page = req.wr && sel_page;
    assign wr_policy = req.wr && sel_policy;
    assign wr_hp = req.wr && sel_hp;

    // ========================================
    // Page select
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            page_q <= `ODP_RST_PAGE_SELECT;
        end else if (wr_page) begin
            page_q <= req.wdata;
        end
    end

    // ========================================
    // Error policy
    logic [7:0] policy_q;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            policy_q <= `ODP_RST_ERROR_POLICY;
        end else if (wr_policy) begin
            policy_q <= req.wdata;
        end
    end

    // ========================================
    // Headphone driver register
    logic hp_left_q;
    logic hp_right_q;
    logic hp_rsvd5_q;
    logic [1:0] hp_cm_q;
    logic hp_rsvd2_q;
    logic hp_mode_q;
    logic hp_trip;

    // A sized literal cannot be bit-selected, so the reset image gets a name
    localparam logic [7:0] HP_RST = `ODP_RST_HP_DRIVER;

    // Only the power-down mode drops the power bits, and only under policy zero
    assign hp_trip = hp_short && hp_mode_q && !policy_q[`ODP_BIT_POL_HP];

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            hp_left_q <= HP_RST[`ODP_BIT_HP_LEFT_PWR];
            hp_right_q <= HP_RST[`ODP_BIT_HP_RIGHT_PWR];
            hp_rsvd5_q <= HP_RST[`ODP_BIT_HP_RSVD_ZERO];
            hp_cm_q <= HP_RST[`ODP_BIT_HP_CM_HI:`ODP_BIT_HP_CM_LO];
            hp_rsvd2_q <= HP_RST[`ODP_BIT_HP_RSVD_ONE];
            hp_mode_q <= HP_RST[`ODP_BIT_HP_PROT_MODE];
        end else begin
            if (wr_hp) begin
                hp_left_q <= req.wdata[`ODP_BIT_HP_LEFT_PWR];
                hp_right_q <= req.wdata[`ODP_BIT_HP_RIGHT_PWR];
                hp_rsvd5_q <= req.wdata[`ODP_BIT_HP_RSVD_ZERO];
                hp_cm_q <= req.wdata[`ODP_BIT_HP_CM_HI:`ODP_BIT_HP_CM_LO];
                hp_rsvd2_q <= req.wdata[`ODP_BIT_HP_RSVD_ONE];
                hp_mode_q <= req.wdata[`ODP_BIT_HP_PROT_MODE];
            end
            // Protection trip overrides a same-cycle power-up write
            if (hp_trip) begin
                hp_left_q <= 1'b0;
                hp_right_q <= 1'b0;
            end
        end
    end

    // ========================================
    // Speaker power bits, written from the speaker amplifier register
    logic sp_left_q;
    logic sp_right_q;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sp_left_q <= 1'b0;
            sp_right_q <= 1'b0;
        end else begin
            if (speaker_pwr_wr) begin
                sp_left_q <= speaker_pwr_wdata[1];
                sp_right_q <= speaker_pwr_wdata[0];
            end
            if (sp_short && !policy_q[`ODP_BIT_POL_SP]) begin
                sp_left_q <= 1'b0;
                sp_right_q <= 1'b0;
            end
        end
    end

    assign left_speaker_driver_pwr = sp_left_q;
    assign right_speaker_driver_pwr = sp_right_q;

    // ========================================
    // Analog control outputs
    always_comb begin
        hp_ctrl.left_headphone_driver_pwr = hp_left_q;
        hp_ctrl.right_headphone_driver_pwr = hp_right_q;
        hp_ctrl.common_mode_sel = hp_cm_q;
        hp_ctrl.protect_power_down = hp_mode_q && hp_short;
        hp_ctrl.protect_limit_current = !hp_mode_q && hp_short;
    end

    // ========================================
    // Read path
    // Gain readback is reloaded from gain_sync every cycle, so a torn code reaches a read one cycle later
    logic [6:0] gain_q;
    logic [7:0] hp_view;
    logic [7:0] rd_mux;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            gain_q <= `ODP_RST_PIN_GAIN;
        end else begin
            gain_q <= gain_sync;
        end
    end

    // Status bit zero is the live synchronised short, not a stored copy
    assign hp_view = {hp_left_q, hp_right_q, hp_rsvd5_q, hp_cm_q, hp_rsvd2_q, hp_mode_q, hp_short};

    // Unmapped numbers read zero so the host never sees stale register data
    always_comb begin
        rd_mux = 8'h00;
        if (sel_page) begin
            rd_mux = page_q;
        end else if (sel_policy) begin
            rd_mux = policy_q;
        end else if (sel_hp) begin
            rd_mux = hp_view;
        end else if (sel_gain) begin
            rd_mux = {1'b0, gain_q};
        end
    end

    // Read data holds between reads so the port decoder may pick it up late
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd;
            if (req.rd) begin
                rdata <= rd_mux;
            end
        end
    end

endmodule

// ==== rtl/odp_sync2.sv ====
// Two-stage level synchroniser, one per bit.
// Assumes the input is asynchronous to clock.
`timescale 1ns/10ps

module odp_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            // First stage feeds only the second stage
            always_ff @(posedge clock) begin
                if (sys_rst) begin
                    meta_q[i] <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    meta_q[i] <= async_in[i];
                    sync_out[i] <= meta_q[i];
                end
            end
        end
    endgenerate

endmodule
